/* File: hdl/kbd_clk_div.sv */
`include "kbd_defs.svh"
`default_nettype none

module kbd_clk_div (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  kbd_div_if.gen div_if
);

  logic [2:0] cnt;
  logic [2:0] last;
  logic [2:0] next_cnt;

  // Reserved codes fall back to the divide-by-four setting.
  always_comb begin
    last = `KBD_DIV4 - 3'h1;
    if (div_if.code == `KBD_DIV_CODE3) begin
      last = `KBD_DIV3 - 3'h1;
    end
    next_cnt = (cnt >= last) ? 3'h0 : cnt + 3'h1;
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cnt <= 3'h0;
      div_if.tick <= 1'b0;
      div_if.bclk <= 1'b1;
    end else begin
      cnt <= next_cnt;
      div_if.tick <= (next_cnt == last);
      div_if.bclk <= (next_cnt < `KBD_BCLK_HIGH);
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_gap3;
    (div_if.code == `KBD_DIV_CODE3)[*2];
  endsequence

  sequence s_gap4;
    (div_if.code == `KBD_DIV_CODE4)[*3];
  endsequence

  a_div_three: assert property (
    (div_if.tick && div_if.code == `KBD_DIV_CODE3) ##1 s_gap3 |-> !div_if.tick ##1 div_if.tick)
    else $error("divide-by-three period wrong");

  // A code change at the tick itself lets the counter run on once, so the code must be settled.
  a_div_four: assert property (
    (div_if.tick && div_if.code == `KBD_DIV_CODE4 && $stable(div_if.code)) ##1 s_gap4 |->
      !div_if.tick ##1 div_if.tick)
    else $error("divide-by-four period wrong");

  // A shorter code that lands on the falling cycle wraps the count before any tick.
  a_bclk_tick: assert property (
    $fell(div_if.bclk) && $stable(div_if.code) |-> ##[0:1] div_if.tick)
    else $error("bus clock low phase not ended by tick");

endmodule

`default_nettype wire

/* File: hdl/kbd_top.sv */
// Design decisions made here: the register offsets and the APB register port.
`include "kbd_defs.svh"
`default_nettype none

module kbd_top (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic pready_out,
  output logic [31:0] prdata_out,
  output logic pslverr_out,
  input wire logic keyboard_interrupt_request_in,
  input wire logic io_read_in,
  input wire logic [15:0] io_addr_in,
  output logic keyboard_irq_to_pic_out,
  output logic bus_clk_out,
  output logic bus_clk_tick_out,
  output logic irq_out
);

  kbd_pkg::kbd_apb_e state;
  kbd_pkg::kbd_apb_e next_state;
  logic [7:0] bus_clock_divisor_control;
  logic [`KBD_INT_W-1:0] int_status;
  logic [`KBD_INT_W-1:0] int_mask;
  logic [`KBD_INT_W-1:0] int_event;
  logic sync_a;
  logic sync_b;
  logic sync_c;
  logic irq_level;
  logic irq_level_d;
  logic irq_edge;
  logic kbd_latch;
  logic port_clear;
  logic keyboard_full_latch_select;
  logic apb_fire;
  logic apb_wr;
  logic addr_hit;
  logic [31:0] rd_mux;
  logic div_bclk;
  logic div_tick;

  kbd_div_if div_if ();

  assign keyboard_full_latch_select = bus_clock_divisor_control[`KBD_SEL_BIT];
  assign apb_fire = psel_in && penable_in && pready_out;
  assign apb_wr = apb_fire && pwrite_in;
  assign port_clear = io_read_in && (io_addr_in == `KBD_PORT_DATA);
  assign irq_edge = irq_level && !irq_level_d;

  // Keyboard request pin synchroniser; the first stage feeds only the second.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_c <= 1'b0;
    end else begin
      sync_a <= keyboard_interrupt_request_in;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  // A pin change counts only once the last two stages agree.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      irq_level <= 1'b0;
      irq_level_d <= 1'b0;
    end else begin
      if (sync_b == sync_c) begin
        irq_level <= sync_c;
      end
      irq_level_d <= irq_level;
    end
  end

  // Edge-detect latch; a new edge wins over a simultaneous port read.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      kbd_latch <= 1'b0;
    end else if (irq_edge) begin
      kbd_latch <= 1'b1;
    end else if (port_clear) begin
      kbd_latch <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      keyboard_irq_to_pic_out <= 1'b0;
    end else if (keyboard_full_latch_select) begin
      keyboard_irq_to_pic_out <= kbd_latch;
    end else begin
      keyboard_irq_to_pic_out <= irq_level;
    end
  end

  // Bus slave: every access phase is answered one cycle after it opens.
  always_comb begin
    next_state = state;
    case (state)
      kbd_pkg::KBD_IDLE: begin
        if (psel_in && penable_in) begin
          next_state = kbd_pkg::KBD_ACK;
        end
      end
      kbd_pkg::KBD_ACK: begin
        next_state = kbd_pkg::KBD_IDLE;
      end
      default: begin
        next_state = kbd_pkg::KBD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state <= kbd_pkg::KBD_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_comb begin
    addr_hit = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr_in)
      `KBD_ADDR_DIVCTL: begin
        rd_mux = {24'h00_0000, bus_clock_divisor_control};
      end
      `KBD_ADDR_STATE: begin
        rd_mux[`KBD_ST_LATCH] = kbd_latch;
        rd_mux[`KBD_ST_LEVEL] = irq_level;
        rd_mux[`KBD_ST_BCLK] = div_bclk;
      end
      `KBD_ADDR_INTSTAT: begin
        rd_mux[`KBD_INT_W-1:0] = int_status;
      end
      `KBD_ADDR_INTMASK: begin
        rd_mux[`KBD_INT_W-1:0] = int_mask;
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pready_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end else if (state == kbd_pkg::KBD_IDLE && psel_in && penable_in) begin
      pready_out <= 1'b1;
      prdata_out <= pwrite_in ? 32'h0000_0000 : rd_mux;
      pslverr_out <= !addr_hit;
    end else begin
      pready_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end
  end

  // Only the select bit and divisor field are writable; the rest reads zero.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      bus_clock_divisor_control <= `KBD_DIVCTL_RESET;
    end else if (apb_wr && paddr_in == `KBD_ADDR_DIVCTL) begin
      bus_clock_divisor_control <= pwdata_in[7:0] & `KBD_DIVCTL_WMASK;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      int_mask <= '0;
    end else if (apb_wr && paddr_in == `KBD_ADDR_INTMASK) begin
      int_mask <= pwdata_in[`KBD_INT_W-1:0];
    end
  end

  always_comb begin
    int_event = '0;
    int_event[`KBD_INT_EDGE] = irq_edge;
    int_event[`KBD_INT_CLEAR] = port_clear && kbd_latch && !irq_edge;
  end

  // Sticky status, cleared by writing ones; a new event wins over the clear.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      int_status <= '0;
    end else if (apb_wr && paddr_in == `KBD_ADDR_INTSTAT) begin
      int_status <= (int_status & ~pwdata_in[`KBD_INT_W-1:0]) | int_event;
    end else begin
      int_status <= int_status | int_event;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(int_status & int_mask);
    end
  end

  assign div_if.code = bus_clock_divisor_control[`KBD_DIV_MSB:`KBD_DIV_LSB];
  assign div_bclk = div_if.bclk;
  assign div_tick = div_if.tick;

  kbd_clk_div u_div (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .div_if(div_if)
  );

  assign bus_clk_out = div_bclk;
  assign bus_clk_tick_out = div_tick;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_pulse_passed;
    (!keyboard_full_latch_select && irq_level) ##1
      (!keyboard_full_latch_select && !irq_level);
  endsequence

  sequence s_edge_latched;
    keyboard_full_latch_select && irq_edge;
  endsequence

  a_select_route: assert property (
    $past(keyboard_full_latch_select) != $past(keyboard_full_latch_select, 2) |->
      keyboard_irq_to_pic_out == ($past(keyboard_full_latch_select) ?
        $past(kbd_latch) : $past(irq_level)))
    else $error("select change did not reroute request");

  a_pass_through: assert property (
    s_pulse_passed |=> !keyboard_irq_to_pic_out)
    else $error("request latched while select is clear");

  a_latch_hold: assert property (
    s_edge_latched ##1 (keyboard_full_latch_select && !port_clear)[*2] |=>
      keyboard_irq_to_pic_out)
    else $error("latched request not presented");

  a_port_clear: assert property (
    port_clear && !irq_edge |=> !kbd_latch ##1 (kbd_latch == $past(irq_edge)))
    else $error("port read did not clear latch");

  a_alias_keep: assert property (
    kbd_latch && !port_clear |=> kbd_latch)
    else $error("latch cleared without exact port read");

  a_reset_divisor: assert property (
    $past(sys_rst_in) |-> div_if.code == `KBD_DIV_CODE4 && keyboard_full_latch_select)
    else $error("reset value of divisor control wrong");

  a_apb_answer: assert property (
    (psel_in && penable_in && !pready_out && state == kbd_pkg::KBD_IDLE) |=> pready_out)
    else $error("access phase not answered in one cycle");

  a_irq_mask: assert property (
    (int_status & int_mask) != '0 |=> irq_out)
    else $error("unmasked status did not raise interrupt");

endmodule

`default_nettype wire

/* File: inc/kbd_defs.svh */
`ifndef KBD_DEFS_SVH
`define KBD_DEFS_SVH

// Register byte addresses on the APB.
`define KBD_ADDR_DIVCTL 8'h00
`define KBD_ADDR_STATE 8'h04
`define KBD_ADDR_INTSTAT 8'h08
`define KBD_ADDR_INTMASK 8'h0C

// Divisor control register layout and reset value.
`define KBD_DIVCTL_RESET 8'h08
`define KBD_DIVCTL_WMASK 8'h0F
`define KBD_SEL_BIT 3
`define KBD_DIV_MSB 2
`define KBD_DIV_LSB 0

// Keyboard data port whose exact I/O read clears the latch.
`define KBD_PORT_DATA 16'h0060

// Divisor codes and the integers they select.
`define KBD_DIV_CODE4 3'h0
`define KBD_DIV_CODE3 3'h1
`define KBD_DIV4 3'h4
`define KBD_DIV3 3'h3
`define KBD_BCLK_HIGH 3'h2

// Interrupt status bit positions and width.
`define KBD_INT_EDGE 0
`define KBD_INT_CLEAR 1
`define KBD_INT_W 2

// State register bit positions.
`define KBD_ST_LATCH 0
`define KBD_ST_LEVEL 1
`define KBD_ST_BCLK 2

`endif

/* File: inc/kbd_div_if.sv */
`default_nettype none

interface kbd_div_if;
  logic [2:0] code;
  logic bclk;
  logic tick;

  modport ctrl (
    output code,
    input bclk,
    input tick
  );

  modport gen (
    input code,
    output bclk,
    output tick
  );
endinterface

`default_nettype wire

/* File: inc/kbd_pkg.sv */
`default_nettype none

package kbd_pkg;

  // Bus slave states, Gray coded along idle, acknowledge.
  typedef enum logic [1:0] {
    KBD_IDLE = 2'b00,
    KBD_ACK = 2'b01
  } kbd_apb_e;

  typedef logic [2:0] kbd_code_t;

endpackage

`default_nettype wire

/* File: verif/kbd_kbc_model.sv */
`default_nettype none

module kbd_kbc_model (
  input wire logic clk_in,
  input wire logic raise_in,
  input wire logic [3:0] delay_in,
  output logic kbd_req_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt = 4'h0;
  logic req = 1'b0;

  assign kbd_req_out = req;

  // The request line follows the command after a chosen delay, so it can answer late.
  always @(posedge clk_in) begin
    if (raise_in == req) begin
      cnt <= 4'h0;
    end else if (cnt >= delay_in) begin
      req <= raise_in;
      cnt <= 4'h0;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule

`default_nettype wire

/* File: verif/tb.sv */
`include "kbd_defs.svh"
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic pready, pslverr, pic, bclk, tick, irq, kreq, io_rd = 1'b0, raise = 1'b0;
  logic [31:0] prdata;
  logic [15:0] io_addr = 16'h0000;
  logic [3:0] dly = 4'h0;
  logic [31:0] seed = 32'hA4AA9BBD;
  logic [31:0] v;
  int n_mismatch = 0;
  int checked = 0;

  always #10 clk_in = ~clk_in;

  kbd_kbc_model i_kbc (.clk_in(clk_in), .raise_in(raise), .delay_in(dly), .kbd_req_out(kreq));

  kbd_top i_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .pready_out(pready), .prdata_out(prdata), .pslverr_out(pslverr),
    .keyboard_interrupt_request_in(kreq), .io_read_in(io_rd), .io_addr_in(io_addr),
    .keyboard_irq_to_pic_out(pic), .bus_clk_out(bclk), .bus_clk_tick_out(tick),
    .irq_out(irq));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Code 001 divides by three; every other code divides by four.
  function automatic int period_of(input logic [2:0] code);
    return (code == `KBD_DIV_CODE3) ? 3 : 4;
  endfunction

  task automatic close_out();
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic hang();
    n_mismatch++;
    $display("FAIL %0t wait ran out", $time);
    close_out();
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int i;
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_in);
      if (pready === 1'b1) break;
    end
    if (i == 20) hang();
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe = 1'b0);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x);
    chk({31'h0, e}, {31'h0, xe});
  endtask

  task automatic wt(input bit s, input logic x);
    int i;
    for (i = 0; i < 40 && (s ? irq : pic) !== x; i++) @(posedge clk_in);
    if (i == 40) hang();
    chk({31'h0, s ? irq : pic}, {31'h0, x});
  endtask

  task automatic per(input int x);
    int i;
    int n;
    int h = 0;
    for (i = 0; i < 10 && tick !== 1'b1; i++) @(posedge clk_in);
    for (n = 1; n < 10; n++) begin
      @(posedge clk_in);
      if (bclk === 1'b1) h++;
      if (tick === 1'b1) break;
    end
    chk(n, x);
    chk(h, `KBD_BCLK_HIGH);
  endtask

  task automatic io(input logic [15:0] a);
    @(posedge clk_in);
    io_rd <= 1'b1;
    io_addr <= a;
    @(posedge clk_in);
    io_rd <= 1'b0;
  endtask

  initial begin
    repeat (6) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    rd(`KBD_ADDR_DIVCTL, 32'h08);
    rd(`KBD_ADDR_INTMASK, 32'h0);
    rd(8'h10, 32'h0, 1'b1);
    per(4);
    // Random settings keep the divisor code at 000 or 001 only.
    repeat (8) begin
      seed = lfsr(seed);
      v = seed & 32'hFFFFFFF9;
      wr(`KBD_ADDR_DIVCTL, v);
      rd(`KBD_ADDR_DIVCTL, v & 32'h0F);
      per(period_of(v[2:0]));
    end
    wr(`KBD_ADDR_DIVCTL, 32'h08);
    wr(`KBD_ADDR_INTMASK, 32'h3);
    dly <= seed[3:0];
    raise <= 1'b1;
    wt(0, 1'b1);
    wt(1, 1'b1);
    raise <= 1'b0;
    repeat (20) @(posedge clk_in);
    chk(pic, 1'b1);
    rd(`KBD_ADDR_INTSTAT, 32'h1);
    wr(`KBD_ADDR_INTSTAT, 32'h1);
    wt(1, 1'b0);
    io(16'h0460);
    repeat (4) @(posedge clk_in);
    chk(pic, 1'b1);
    io(`KBD_PORT_DATA);
    wt(0, 1'b0);
    rd(`KBD_ADDR_INTSTAT, 32'h2);
    wr(`KBD_ADDR_INTSTAT, 32'h2);
    wr(`KBD_ADDR_DIVCTL, 32'h01);
    per(3);
    raise <= 1'b1;
    wt(0, 1'b1);
    raise <= 1'b0;
    wt(0, 1'b0);
    wr(`KBD_ADDR_INTMASK, 32'h0);
    repeat (3) @(posedge clk_in);
    chk(irq, 1'b0);
    rd(`KBD_ADDR_INTSTAT, 32'h1);
    close_out();
  end
endmodule

`default_nettype wire
